// [inc/bsc_map.svh]
/*
 * Offsets, field positions, reset values and cycle counts of the
 * branch, skip and compare unit.
 * Assumes inclusion by bare name from the package and the unit.
 */
`ifndef BSC_MAP_SVH
`define BSC_MAP_SVH

// ==========================================================
// Register offsets (byte addresses) and address width
`define BSC_CTRL_OFFSET 4'h0
`define BSC_FLAGS_OFFSET 4'h4
`define BSC_PC_OFFSET 4'h8
`define BSC_COUNT_OFFSET 4'hC
`define BSC_ADDR_WIDTH 8

// ==========================================================
// Reset values
`define BSC_CTRL_RESET 1'h1
`define BSC_FLAGS_RESET 8'h00
`define BSC_PC_RESET 16'h0000

// ==========================================================
// Status flag positions
`define BSC_FLAG_C 3'h0
`define BSC_FLAG_Z 3'h1
`define BSC_FLAG_N 3'h2
`define BSC_FLAG_V 3'h3
`define BSC_FLAG_S 3'h4
`define BSC_FLAG_H 3'h5
`define BSC_FLAG_T 3'h6
`define BSC_FLAG_I 3'h7

// ==========================================================
// Cycle counts, stored as count minus one, and the fill value
`define BSC_WAIT_JUMP 2'h1
`define BSC_WAIT_CALL 2'h2
`define BSC_WAIT_SKIP1 2'h1
`define BSC_WAIT_SKIP2 2'h2
`define BSC_WAIT_BRANCH 2'h1
`define BSC_ALL_ONES 8'hFF

// ==========================================================
// Bus answers
`define BSC_RESP_OKAY 2'h0
`define BSC_RESP_SLVERR 2'h2

`endif

// [inc/bsc_pkg.sv]
/*
 * Types of the branch, skip and compare unit.
 * Assumes bsc_map.svh is on the include path.
 */
`include "bsc_map.svh"

package bsc_pkg;

  // ==========================================================
  // Operations
  typedef enum logic [4:0] {
    OP_NONE = 5'h00,
    OP_TEST_REGISTER = 5'h01,
    OP_ZERO_REGISTER = 5'h02,
    OP_FILL_REGISTER_ONES = 5'h03,
    OP_RELATIVE_JUMP = 5'h04,
    OP_POINTER_JUMP = 5'h05,
    OP_RELATIVE_CALL = 5'h06,
    OP_POINTER_CALL = 5'h07,
    OP_COMPARE_SKIP_EQUAL = 5'h08,
    OP_COMPARE_REGS = 5'h09,
    OP_COMPARE_REGS_WITH_BORROW = 5'h0A,
    OP_COMPARE_IMMEDIATE = 5'h0B,
    OP_SKIP_REG_BIT_CLEAR = 5'h0C,
    OP_SKIP_REG_BIT_SET = 5'h0D,
    OP_SKIP_IO_BIT_CLEAR = 5'h0E,
    OP_SKIP_IO_BIT_SET = 5'h0F,
    OP_BRANCH_FLAG_SET = 5'h10,
    OP_BRANCH_FLAG_CLEAR = 5'h11,
    OP_BRANCH_SIGNED_GE = 5'h12,
    OP_BRANCH_SIGNED_LT = 5'h13
  } bsc_op_e;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } bsc_state_e;

  // ==========================================================
  // Instruction from the core
  typedef struct packed {
    bsc_op_e op;
    logic [7:0] a_val;
    logic [7:0] b_val;
    logic [11:0] offset;
    logic [2:0] bit_sel;
    logic [2:0] flag_sel;
    logic [7:0] io_val;
    logic next_two_word;
    logic [15:0] z_ptr;
  } bsc_instr_s;

  // Effects handed back to the core
  typedef struct packed {
    logic reg_wr;
    logic [7:0] reg_wr_data;
    logic push;
    logic [15:0] push_addr;
  } bsc_result_s;

endpackage

// [verilog/bsc_unit.sv]
/*
 * Branch, skip and compare unit of an 8-bit core with an AXI4-Lite
 * register slave. Assumes the core supplies operand values, the
 * addressed I/O byte and the Z pointer with each instruction, and
 * performs the register write and the stack push that it is given.
 */
// How it works
// - Test ANDs register, clear XORs it, fill loads FF without flags
// - Relative jump loads pc+k+1 in 2 cycles; call pushes, 3 cycles
// - Pointer jump loads pc from Z, no flags, 2 cycles
// - Pointer call pushes return, loads pc from Z, 3 cycles
// - Compare-skip-equal skips next instruction when equal, no flags
// - Compares subtract without storing, set Z N V C H, 1 cycle
// - Skip when selected register bit is zero
// - Skip when selected register bit is one
// - Skip when selected I/O bit is zero
// - Skip when selected I/O bit is one
// - Branch when selected flag set; equal uses Z, minus uses N
// - Branch when selected flag clear; not-equal Z, plus N
// - Carry-set branch on C one, carry-clear branch on C zero
// - Same-or-higher equals carry-clear, lower equals carry-set
// - Signed greater-or-equal branch when N xor V is zero
// - Signed less-than branch when N xor V is one
// - Half-carry-set branch on H one, flags unchanged
// - Half-carry-clear branch on H zero, flags unchanged
// - Transfer-bit-set branch on T one
// - Transfer-bit-clear branch on T zero, same timing
`timescale 1ns/1ns
`include "bsc_map.svh"

module bsc_unit
  import bsc_pkg::*;
(
  // Clock and reset
  input logic core_clk,
  input logic rst_n,
  // Core instruction port
  input logic instr_valid_i,
  input bsc_instr_s instr_i,
  output logic instr_ready_o,
  output logic done_o,
  output logic [15:0] pc_o,
  output logic [7:0] flags_o,
  output bsc_result_s result_o,
  // AXI4-Lite slave
  input logic [`BSC_ADDR_WIDTH-1:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [`BSC_ADDR_WIDTH-1:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready
);

  // ==========================================================
  // Bus slave
  logic aw_held_reg, aw_held_next;
  logic [`BSC_ADDR_WIDTH-1:0] awaddr_reg, awaddr_next;
  logic w_held_reg, w_held_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic enable_reg, enable_next;
  logic [15:0] count_reg, count_next;
  logic [31:0] wmerge;
  logic wr_fire, sw_flags_wr, sw_pc_wr;

  // Core state
  bsc_state_e state_reg, state_next;
  logic [1:0] wait_reg, wait_next;
  logic [15:0] pc_reg, pc_next;
  logic [7:0] flags_reg, flags_next;
  logic ready_reg, ready_next;
  logic done_reg, done_next;
  bsc_result_s result_reg, result_next;
  logic take;

  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
    input logic [31:0] new_v, input logic [3:0] strb);
    logic [31:0] m;
    m = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        m[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return m;
  endfunction

  always_comb
  begin
    aw_held_next = aw_held_reg;
    awaddr_next = awaddr_reg;
    w_held_next = w_held_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    arready_next = arready_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    enable_next = enable_reg;
    wr_fire = 1'b0;
    sw_flags_wr = 1'b0;
    sw_pc_wr = 1'b0;
    wmerge = 32'h00000000;
    if (s_axi_awvalid && awready_reg)
    begin
      aw_held_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg)
    begin
      w_held_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (bvalid_reg && s_axi_bready)
    begin
      bvalid_next = 1'b0;
    end
    if (aw_held_reg && w_held_reg && !bvalid_reg)
    begin
      wr_fire = 1'b1;
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = `BSC_RESP_OKAY;
      case (awaddr_reg[3:0])
        `BSC_CTRL_OFFSET:
        begin
          wmerge = lane_merge({31'h0, enable_reg}, wdata_reg, wstrb_reg);
          enable_next = wmerge[0];
        end
        `BSC_FLAGS_OFFSET:
          sw_flags_wr = wstrb_reg[0];
        `BSC_PC_OFFSET:
        begin
          wmerge = lane_merge({16'h0, pc_reg}, wdata_reg, wstrb_reg);
          sw_pc_wr = 1'b1;
        end
        `BSC_COUNT_OFFSET:
          bresp_next = `BSC_RESP_OKAY;
        default:
          bresp_next = `BSC_RESP_SLVERR;
      endcase
      if (awaddr_reg[`BSC_ADDR_WIDTH-1:4] != '0 || awaddr_reg[1:0] != 2'h0)
      begin
        bresp_next = `BSC_RESP_SLVERR;
        enable_next = enable_reg;
        sw_flags_wr = 1'b0;
        sw_pc_wr = 1'b0;
      end
    end
    awready_next = !aw_held_next;
    wready_next = !w_held_next;
    if (rvalid_reg && s_axi_rready)
    begin
      rvalid_next = 1'b0;
      arready_next = 1'b1;
    end
    if (s_axi_arvalid && arready_reg)
    begin
      arready_next = 1'b0;
      rvalid_next = 1'b1;
      rresp_next = `BSC_RESP_OKAY;
      case (s_axi_araddr[3:0])
        `BSC_CTRL_OFFSET: rdata_next = {31'h0, enable_reg};
        `BSC_FLAGS_OFFSET: rdata_next = {24'h0, flags_reg};
        `BSC_PC_OFFSET: rdata_next = {16'h0, pc_reg};
        `BSC_COUNT_OFFSET: rdata_next = {16'h0, count_reg};
        default:
        begin
          rdata_next = 32'h00000000;
          rresp_next = `BSC_RESP_SLVERR;
        end
      endcase
      if (s_axi_araddr[`BSC_ADDR_WIDTH-1:4] != '0 ||
          s_axi_araddr[1:0] != 2'h0)
      begin
        rdata_next = 32'h00000000;
        rresp_next = `BSC_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= '0;
      w_held_reg <= 1'b0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= `BSC_RESP_OKAY;
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `BSC_RESP_OKAY;
      enable_reg <= `BSC_CTRL_RESET;
    end
    else
    begin
      aw_held_reg <= aw_held_next;
      awaddr_reg <= awaddr_next;
      w_held_reg <= w_held_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      enable_reg <= enable_next;
    end
  end

  // ==========================================================
  // Execution
  logic [15:0] pc_inc, pc_rel, offset_ext;
  logic [8:0] diff;
  logic [7:0] a, b, r;
  logic cond, skip, is_cmp;

  always_comb
  begin
    take = instr_valid_i && ready_reg;
    a = instr_i.a_val;
    b = instr_i.b_val;
    offset_ext = {{4{instr_i.offset[11]}}, instr_i.offset};
    pc_inc = pc_reg + 16'h0001;
    pc_rel = pc_reg + offset_ext + 16'h0001;
    diff = {1'b0, a} - {1'b0, b} -
      {8'h00, instr_i.op == OP_COMPARE_REGS_WITH_BORROW &&
      flags_reg[`BSC_FLAG_C]};
    r = diff[7:0];
    cond = 1'b0;
    skip = 1'b0;
    is_cmp = 1'b0;
    state_next = state_reg;
    wait_next = wait_reg;
    pc_next = pc_reg;
    flags_next = flags_reg;
    done_next = 1'b0;
    result_next = '0;
    count_next = count_reg;
    if (sw_flags_wr)
    begin
      flags_next = wdata_reg[7:0];
    end
    if (sw_pc_wr)
    begin
      pc_next = wmerge[15:0];
    end
    if (state_reg == ST_BUSY)
    begin
      wait_next = wait_reg - 2'h1;
      if (wait_reg == 2'h1)
      begin
        state_next = ST_IDLE;
        done_next = 1'b1;
      end
    end
    if (take)
    begin
      count_next = count_reg + 16'h0001;
      pc_next = pc_inc;
      wait_next = 2'h0;
      case (instr_i.flag_sel)
        `BSC_FLAG_Z: cond = flags_reg[`BSC_FLAG_Z];
        `BSC_FLAG_N: cond = flags_reg[`BSC_FLAG_N];
        `BSC_FLAG_C: cond = flags_reg[`BSC_FLAG_C];
        `BSC_FLAG_H: cond = flags_reg[`BSC_FLAG_H];
        `BSC_FLAG_T: cond = flags_reg[`BSC_FLAG_T];
        default: cond = flags_reg[instr_i.flag_sel];
      endcase
      case (instr_i.op)
        OP_TEST_REGISTER, OP_ZERO_REGISTER:
        begin
          r = (instr_i.op == OP_TEST_REGISTER) ? (a & a) : (a ^ a);
          result_next.reg_wr = 1'b1;
          result_next.reg_wr_data = r;
          flags_next[`BSC_FLAG_Z] = (r == 8'h00);
          flags_next[`BSC_FLAG_N] = r[7];
          flags_next[`BSC_FLAG_V] = 1'b0;
        end
        OP_FILL_REGISTER_ONES:
        begin
          result_next.reg_wr = 1'b1;
          result_next.reg_wr_data = `BSC_ALL_ONES;
        end
        OP_RELATIVE_JUMP:
        begin
          pc_next = pc_rel;
          wait_next = `BSC_WAIT_JUMP;
        end
        OP_POINTER_JUMP:
        begin
          pc_next = instr_i.z_ptr;
          wait_next = `BSC_WAIT_JUMP;
        end
        OP_RELATIVE_CALL, OP_POINTER_CALL:
        begin
          pc_next = (instr_i.op == OP_POINTER_CALL) ? instr_i.z_ptr :
            pc_rel;
          result_next.push = 1'b1;
          result_next.push_addr = pc_inc;
          wait_next = `BSC_WAIT_CALL;
        end
        OP_COMPARE_SKIP_EQUAL: skip = (a == b);
        OP_SKIP_REG_BIT_CLEAR: skip = !a[instr_i.bit_sel];
        OP_SKIP_REG_BIT_SET: skip = a[instr_i.bit_sel];
        OP_SKIP_IO_BIT_CLEAR: skip = !instr_i.io_val[instr_i.bit_sel];
        OP_SKIP_IO_BIT_SET: skip = instr_i.io_val[instr_i.bit_sel];
        OP_COMPARE_REGS, OP_COMPARE_REGS_WITH_BORROW, OP_COMPARE_IMMEDIATE:
          is_cmp = 1'b1;
        OP_BRANCH_FLAG_SET:
          if (cond)
          begin
            pc_next = pc_rel;
            wait_next = `BSC_WAIT_BRANCH;
          end
        OP_BRANCH_FLAG_CLEAR:
          if (!cond)
          begin
            pc_next = pc_rel;
            wait_next = `BSC_WAIT_BRANCH;
          end
        OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT:
          if ((flags_reg[`BSC_FLAG_N] ^ flags_reg[`BSC_FLAG_V]) ==
              (instr_i.op == OP_BRANCH_SIGNED_LT))
          begin
            pc_next = pc_rel;
            wait_next = `BSC_WAIT_BRANCH;
          end
        default:
          pc_next = pc_inc;
      endcase
      if (skip)
      begin
        pc_next = pc_reg + (instr_i.next_two_word ? 16'h0003 : 16'h0002);
        wait_next = instr_i.next_two_word ? `BSC_WAIT_SKIP2 :
          `BSC_WAIT_SKIP1;
      end
      if (is_cmp)
      begin
        flags_next[`BSC_FLAG_Z] = (r == 8'h00) &&
          (instr_i.op != OP_COMPARE_REGS_WITH_BORROW ||
          flags_reg[`BSC_FLAG_Z]);
        flags_next[`BSC_FLAG_N] = r[7];
        flags_next[`BSC_FLAG_V] = (a[7] & ~b[7] & ~r[7]) |
          (~a[7] & b[7] & r[7]);
        flags_next[`BSC_FLAG_C] = (~a[7] & b[7]) | (b[7] & r[7]) |
          (r[7] & ~a[7]);
        flags_next[`BSC_FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) |
          (r[3] & ~a[3]);
      end
      state_next = (wait_next == 2'h0) ? ST_IDLE : ST_BUSY;
      done_next = (wait_next == 2'h0);
    end
    ready_next = enable_reg && state_next == ST_IDLE;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
      wait_reg <= 2'h0;
      pc_reg <= `BSC_PC_RESET;
      flags_reg <= `BSC_FLAGS_RESET;
      ready_reg <= 1'b0;
      done_reg <= 1'b0;
      result_reg <= '0;
      count_reg <= 16'h0000;
    end
    else
    begin
      state_reg <= state_next;
      wait_reg <= wait_next;
      pc_reg <= pc_next;
      flags_reg <= flags_next;
      ready_reg <= ready_next;
      done_reg <= done_next;
      result_reg <= result_next;
      count_reg <= count_next;
    end
  end

  assign instr_ready_o = ready_reg;
  assign done_o = done_reg;
  assign pc_o = pc_reg;
  assign flags_o = flags_reg;
  assign result_o = result_reg;
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  fill_no_flags_a: assert property (
    take && instr_i.op == OP_FILL_REGISTER_ONES && !sw_flags_wr |=>
    result_o.reg_wr && result_o.reg_wr_data == 8'hFF &&
    flags_o == $past(flags_o))
    else $error("fill did not load all ones or touched flags");
  rel_jump_a: assert property (
    take && instr_i.op == OP_RELATIVE_JUMP && !sw_pc_wr |=>
    pc_o == $past(pc_rel) ##0 !instr_ready_o ##1 instr_ready_o)
    else $error("relative jump target or timing wrong");
  ptr_jump_a: assert property (
    take && instr_i.op == OP_POINTER_JUMP && !sw_pc_wr |=>
    pc_o == $past(instr_i.z_ptr) && done_o == 1'b0 ##1 done_o)
    else $error("pointer jump target or timing wrong");
  ptr_call_a: assert property (
    take && instr_i.op == OP_POINTER_CALL |=>
    result_o.push && result_o.push_addr == $past(pc_o) + 16'h0001
    ##0 !instr_ready_o ##1 !instr_ready_o ##1 done_o)
    else $error("pointer call push or timing wrong");
  skip_two_word_a: assert property (
    take && skip && instr_i.next_two_word && !sw_pc_wr |=>
    pc_o == $past(pc_o) + 16'h0003 ##0 !done_o[*2] ##1 done_o)
    else $error("skip over two words wrong");
  cmp_equal_a: assert property (
    take && instr_i.op == OP_COMPARE_REGS && a == b && !sw_flags_wr |=>
    flags_o[`BSC_FLAG_Z] && !flags_o[`BSC_FLAG_C] && done_o)
    else $error("equal compare flags wrong");
  branch_untaken_a: assert property (
    take && instr_i.op == OP_BRANCH_FLAG_SET && !cond && !sw_pc_wr |=>
    pc_o == $past(pc_o) + 16'h0001 && done_o)
    else $error("untaken branch not one cycle");
  signed_lt_a: assert property (
    take && instr_i.op == OP_BRANCH_SIGNED_LT && !sw_pc_wr && !sw_flags_wr &&
    (flags_o[`BSC_FLAG_N] ^ flags_o[`BSC_FLAG_V]) |=>
    pc_o == $past(pc_rel) && $stable(flags_o))
    else $error("signed less-than branch wrong");

  call_cov: cover property (take && instr_i.op == OP_RELATIVE_CALL);
  skip_cov: cover property (take && skip && instr_i.next_two_word);
  branch_cov: cover property (take && instr_i.op == OP_BRANCH_FLAG_CLEAR
    && !cond);
  bus_wr_cov: cover property (wr_fire && sw_flags_wr);

endmodule // bsc_unit

// [testbench/test_branch_skip_compare_unit.sv]
/* Self-checking bench of the branch, skip and compare unit.
   Assumes bsc_pkg and bsc_map.svh are compiled and on the include path. */
`timescale 1ns/1ns
`include "bsc_map.svh"
module test_branch_skip_compare_unit;
  import bsc_pkg::*;
  logic core_clk = 0, rst_n = 0, instr_valid_i = 0;
  bsc_instr_s instr_i = '0;
  logic instr_ready_o, done_o;
  logic [15:0] pc_o;
  logic [7:0] flags_o;
  bsc_result_s result_o;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int n_fail = 0, num_checks = 0, tmo = 0, nrun = 0;
  always #5 core_clk = ~core_clk;
  bsc_unit bsc_unit_inst (.core_clk(core_clk), .rst_n(rst_n),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i),
    .instr_ready_o(instr_ready_o), .done_o(done_o), .pc_o(pc_o),
    .flags_o(flags_o), .result_o(result_o),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  // ==========================================================
  // Checking and bus tasks
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    tmo++;
    if (tmo > 30000)
    begin
      n_fail++;
      final_report;
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  // ==========================================================
  // Instruction runner and expectations
  task run(input bsc_instr_s ins, input logic [15:0] p, input logic [7:0] f,
           input logic [15:0] epc, input int c, input logic [7:0] ef,
           input bsc_result_s er);
    logic [1:0] r;
    int n;
    axw(8'h08, {16'h0, p}, r);
    axw(8'h04, {24'h0, f}, r);
    chk(r, `BSC_RESP_OKAY);
    @(posedge core_clk);
    instr_valid_i <= 1;
    instr_i <= ins;
    @(posedge core_clk);
    while (instr_ready_o !== 1'b1) @(posedge core_clk);
    instr_valid_i <= 0;
    nrun++;
    #1;
    chk(pc_o, epc);
    chk(flags_o, ef);
    chk(result_o.push, er.push);
    if (er.push) chk(result_o.push_addr, er.push_addr);
    chk(result_o.reg_wr, er.reg_wr);
    if (er.reg_wr) chk(result_o.reg_wr_data, er.reg_wr_data);
    n = 1;
    while (done_o !== 1'b1 && n < 6)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk(32'(n), 32'(c));
  endtask
  function automatic bsc_instr_s rnd(input bsc_op_e o);
    bsc_instr_s x;
    x = {$urandom, $urandom};
    x.op = o;
    return x;
  endfunction
  function automatic logic [15:0] tgt(input logic [15:0] p,
                                      input logic [11:0] k);
    return p + {{4{k[11]}}, k} + 16'h1;
  endfunction
  function automatic logic [7:0] cmpf(input logic [7:0] a, input logic [7:0] b,
                                      input logic ci, input logic [7:0] f,
                                      input logic kz);
    logic [8:0] r;
    logic [7:0] o;
    r = {1'b0, a} - {1'b0, b} - {8'h0, ci};
    o = f;
    o[`BSC_FLAG_C] = r[8];
    o[`BSC_FLAG_Z] = (r[7:0] == 8'h00) && (!kz || f[`BSC_FLAG_Z]);
    o[`BSC_FLAG_N] = r[7];
    o[`BSC_FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    o[`BSC_FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
    return o;
  endfunction
  function automatic logic [7:0] lg(input logic [7:0] v, input logic [7:0] f);
    logic [7:0] o;
    o = f;
    o[`BSC_FLAG_Z] = (v == 8'h00);
    o[`BSC_FLAG_N] = v[7];
    o[`BSC_FLAG_V] = 1'b0;
    return o;
  endfunction
  // ==========================================================
  // Main sequence
  bsc_op_e sk[5] = '{OP_COMPARE_SKIP_EQUAL, OP_SKIP_REG_BIT_CLEAR,
    OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET};
  bsc_op_e cm[6] = '{OP_COMPARE_REGS, OP_COMPARE_REGS_WITH_BORROW,
    OP_COMPARE_IMMEDIATE, OP_TEST_REGISTER, OP_ZERO_REGISTER,
    OP_FILL_REGISTER_ONES};
  bsc_op_e jp[4] = '{OP_RELATIVE_JUMP, OP_POINTER_JUMP, OP_RELATIVE_CALL,
    OP_POINTER_CALL};
  initial
  begin
    bsc_instr_s ins;
    bsc_result_s er;
    logic [31:0] d;
    logic [1:0] r;
    logic [15:0] p, e;
    logic [7:0] f, ef;
    logic tk;
    void'($urandom(45911));
    repeat (8) @(posedge core_clk);
    rst_n <= 1;
    axr(8'h00, d, r);
    chk(d, 32'h1);
    axr(8'h04, d, r);
    chk(d, 32'h0);
    axw(8'h0C, 32'h5, r);
    chk(r, `BSC_RESP_OKAY);
    axr(8'h0C, d, r);
    chk(d, 32'h0);
    axr(8'h10, d, r);
    chk(r, `BSC_RESP_SLVERR);
    axw(8'h02, 32'h1, r);
    chk(r, `BSC_RESP_SLVERR);
    s_axi_wstrb <= 4'hE;
    axw(8'h04, 32'hFF, r);
    s_axi_wstrb <= 4'hF;
    chk(r, `BSC_RESP_OKAY);
    axr(8'h04, d, r);
    chk(d, 32'h0);
    for (int i = 0; i < 56; i++)
    begin
      ins = rnd(i < 48 ? (i[0] ? OP_BRANCH_FLAG_CLEAR : OP_BRANCH_FLAG_SET)
                       : (i[0] ? OP_BRANCH_SIGNED_LT : OP_BRANCH_SIGNED_GE));
      ins.flag_sel = i[3:1];
      f = 8'($urandom);
      p = 16'($urandom);
      tk = i < 48 ? f[ins.flag_sel] == !i[0]
                  : (f[`BSC_FLAG_N] ^ f[`BSC_FLAG_V]) == i[0];
      run(ins, p, f, tk ? tgt(p, ins.offset) : p + 16'h1, tk ? 2 : 1, f,
          '0);
    end
    for (int i = 0; i < 16; i++)
    begin
      ins = rnd(jp[i % 4]);
      p = i < 4 ? 16'h0000 : 16'($urandom);
      if (i < 4) ins.offset = 12'h800;
      f = 8'($urandom);
      er = '0;
      er.push = i[1];
      er.push_addr = p + 16'h1;
      e = i[0] ? ins.z_ptr : tgt(p, ins.offset);
      run(ins, p, f, e, i[1] ? 3 : 2, f, er);
    end
    for (int i = 0; i < 40; i++)
    begin
      ins = rnd(sk[i % 5]);
      if ($urandom % 2 || i % 5 == 1 || i % 5 == 2) ins.b_val = ins.a_val;
      case (i % 5)
        0: tk = ins.a_val == ins.b_val;
        1: tk = !ins.a_val[ins.bit_sel];
        2: tk = ins.a_val[ins.bit_sel];
        3: tk = !ins.io_val[ins.bit_sel];
        default: tk = ins.io_val[ins.bit_sel];
      endcase
      f = 8'($urandom);
      p = 16'($urandom);
      d = tk ? (ins.next_two_word ? 3 : 2) : 1;
      run(ins, p, f, p + d[15:0], int'(d), f, '0);
    end
    for (int i = 0; i < 36; i++)
    begin
      ins = rnd(cm[i % 6]);
      if (i < 6) ins.b_val = ins.a_val;
      f = 8'($urandom);
      p = 16'($urandom);
      er = '0;
      case (i % 6)
        0, 2: ef = cmpf(ins.a_val, ins.b_val, 1'b0, f, 1'b0);
        1: ef = cmpf(ins.a_val, ins.b_val, f[`BSC_FLAG_C], f, 1'b1);
        3: ef = lg(ins.a_val, f);
        4: ef = lg(8'h00, f);
        default: ef = f;
      endcase
      er.reg_wr = i % 6 > 2;
      er.reg_wr_data = i % 6 == 3 ? ins.a_val :
                       i % 6 == 4 ? 8'h00 : `BSC_ALL_ONES;
      run(ins, p, f, p + 16'h1, 1, ef, er);
    end
    axw(8'h00, 32'h0, r);
    @(posedge core_clk);
    instr_valid_i <= 1;
    repeat (3) @(posedge core_clk);
    chk(instr_ready_o, 1'b0);
    instr_valid_i <= 0;
    axw(8'h00, 32'h1, r);
    axr(8'h0C, d, r);
    chk(d, 32'(nrun));
    // Reset in mid-run: state cleared, ready back one edge after release
    rst_n <= 0;
    @(posedge core_clk);
    #1;
    chk(pc_o, 32'h0);
    chk(flags_o, 32'h0);
    chk(instr_ready_o, 1'b0);
    @(posedge core_clk);
    rst_n <= 1;
    @(posedge core_clk);
    #1;
    chk(instr_ready_o, 1'b1);
    chk(done_o, 1'b0);
    final_report;
  end
endmodule // test_branch_skip_compare_unit
